// ---- rtl/cmm_defs.svh ----
// constants shared by the colour matrix multiplier ends
`ifndef CMM_DEFS_SVH
`define CMM_DEFS_SVH
// ----------------------------------------
// datapath widths and timing
// ----------------------------------------
`define CMM_DATA_W 12
`define CMM_COEF_W 10
`define CMM_PROD_W 22
`define CMM_ACC_W 24
`define CMM_FRAC_BITS 9
`define CMM_ROUND_HALF 24'h000100
`define CMM_LATENCY 5
`define CMM_CHANS 3
`define CMM_WIDE_W 16
`define CMM_DATA_MAX 16'sh07ff
`define CMM_DATA_MIN 16'shf800
// ----------------------------------------
// coefficient write select codes
// ----------------------------------------
`define CMM_SEL_HOLD 2'h0
`define CMM_SEL_ONE 2'h1
`define CMM_SEL_TWO 2'h2
`define CMM_SEL_THREE 2'h3
// ----------------------------------------
// controller register map
// ----------------------------------------
`define CMM_REG_COEF 4'h0
`define CMM_REG_CMD 4'h4
`define CMM_REG_SCALE 4'h8
`define CMM_REG_STATUS 4'hc
`define CMM_COEF_RST 32'h00000000
`define CMM_SCALE_RST 2'h0
`define CMM_RESP_OKAY 2'h0
`define CMM_RESP_SLVERR 2'h2
`endif

// ---- rtl/cmm_pkg.sv ----
// types shared by the colour matrix multiplier ends
`include "cmm_defs.svh"
package cmm_pkg;
  typedef logic signed [`CMM_DATA_W-1:0] data_t;
  typedef logic signed [`CMM_COEF_W-1:0] coef_t;
  typedef logic signed [`CMM_PROD_W-1:0] prod_t;
  typedef logic signed [`CMM_ACC_W-1:0] acc_t;
  typedef enum logic [1:0] {
    SEL_HOLD = `CMM_SEL_HOLD,
    SEL_ONE = `CMM_SEL_ONE,
    SEL_TWO = `CMM_SEL_TWO,
    SEL_THREE = `CMM_SEL_THREE
  } sel_t;
endpackage

// ---- rtl/cmm_if.sv ----
// pixel and coefficient link between the matrix multiplier and its host
`timescale 1ns/100ps
`include "cmm_defs.svh"
interface cmm_if
(
  input wire logic aclk,
  input wire logic aresetn
);
  logic [`CMM_DATA_W-1:0] in_chan_first;
  logic [`CMM_DATA_W-1:0] in_chan_second;
  logic [`CMM_DATA_W-1:0] in_chan_third;
  logic [`CMM_COEF_W-1:0] coef_port_first;
  logic [`CMM_COEF_W-1:0] coef_port_second;
  logic [`CMM_COEF_W-1:0] coef_port_third;
  logic [1:0] coef_write_select;
  logic [`CMM_DATA_W-1:0] out_chan_first;
  logic [`CMM_DATA_W-1:0] out_chan_second;
  logic [`CMM_DATA_W-1:0] out_chan_third;

  modport dev
  (
    input aclk, aresetn,
    input in_chan_first, in_chan_second, in_chan_third,
    input coef_port_first, coef_port_second, coef_port_third,
    input coef_write_select,
    output out_chan_first, out_chan_second, out_chan_third
  );

  modport host
  (
    input aclk, aresetn,
    output in_chan_first, in_chan_second, in_chan_third,
    output coef_port_first, coef_port_second, coef_port_third,
    output coef_write_select,
    input out_chan_first, out_chan_second, out_chan_third
  );
endinterface // cmm_if

// ---- rtl/cmm_device.sv ----
// device end: pipelined 3x3 colour matrix multiplier
`timescale 1ns/100ps
`include "cmm_defs.svh"
// ----------------------------------------
// What this block does
// - all ports sampled and updated on rising edge
// - each output sums three products, own set
// - result appears five cycles after input registration
// - new input and result every cycle
// - data words are 12-bit two's complement
// - coefficients are 10-bit fractional two's complement
// - round to 12 bits only at output
// - coefficient words written one edge after registration
// - select 00 hold, 01/10/11 set one-three
// - each port loads only its own coefficients
// - driver right-justifies and sign-extends narrow data
// - low bits kept; high bits give headroom
// - driver clamps upscaled words to the 12-bit range
// - rescale input and output by same factor
// ----------------------------------------
module cmm_device
(
  cmm_if.dev link
);

  // ----------------------------------------
  // arithmetic helpers
  // ----------------------------------------
  function automatic cmm_pkg::prod_t mul_word
  (
    input cmm_pkg::data_t d,
    input cmm_pkg::coef_t k
  );
    mul_word = d * k;
  endfunction

  function automatic cmm_pkg::acc_t widen
  (
    input cmm_pkg::prod_t p
  );
    widen = {{(`CMM_ACC_W-`CMM_PROD_W){p[`CMM_PROD_W-1]}}, p};
  endfunction

  // coefficient is k/512, so nine fraction bits drop here
  function automatic cmm_pkg::data_t round_word
  (
    input cmm_pkg::acc_t a
  );
    cmm_pkg::acc_t r;
    r = a + `CMM_ROUND_HALF;
    round_word = r[`CMM_FRAC_BITS +: `CMM_DATA_W];
  endfunction

  // ----------------------------------------
  // input registers
  // ----------------------------------------
  cmm_pkg::data_t in_ff [`CMM_CHANS];
  cmm_pkg::data_t nxt_in [`CMM_CHANS];
  cmm_pkg::coef_t kin_ff [`CMM_CHANS];
  cmm_pkg::coef_t nxt_kin [`CMM_CHANS];
  cmm_pkg::sel_t sel_ff;
  cmm_pkg::sel_t nxt_sel;

  always_comb
  begin
    nxt_in[0] = link.in_chan_first;
    nxt_in[1] = link.in_chan_second;
    nxt_in[2] = link.in_chan_third;
    nxt_kin[0] = link.coef_port_first;
    nxt_kin[1] = link.coef_port_second;
    nxt_kin[2] = link.coef_port_third;
    nxt_sel = cmm_pkg::sel_t'(link.coef_write_select);
  end

  // only the select is reset; the datapath has none
  always_ff @(posedge link.aclk)
  begin
    in_ff <= nxt_in;
    kin_ff <= nxt_kin;
    if (!link.aresetn)
    begin
      sel_ff <= cmm_pkg::SEL_HOLD;
    end
    else
    begin
      sel_ff <= nxt_sel;
    end
  end

  // ----------------------------------------
  // coefficient bank, [set][port]
  // ----------------------------------------
  cmm_pkg::coef_t coef_ff [`CMM_CHANS][`CMM_CHANS];
  cmm_pkg::coef_t nxt_coef [`CMM_CHANS][`CMM_CHANS];

  // no reset: a set is undefined until first written
  always_comb
  begin
    nxt_coef = coef_ff;
    case (sel_ff)
      cmm_pkg::SEL_HOLD:
      begin
        nxt_coef = coef_ff;
      end
      cmm_pkg::SEL_ONE:
      begin
        for (int p = 0; p < `CMM_CHANS; p++)
        begin
          nxt_coef[0][p] = kin_ff[p];
        end
      end
      cmm_pkg::SEL_TWO:
      begin
        for (int p = 0; p < `CMM_CHANS; p++)
        begin
          nxt_coef[1][p] = kin_ff[p];
        end
      end
      cmm_pkg::SEL_THREE:
      begin
        for (int p = 0; p < `CMM_CHANS; p++)
        begin
          nxt_coef[2][p] = kin_ff[p];
        end
      end
      default:
      begin
        nxt_coef = coef_ff;
      end
    endcase
  end

  always_ff @(posedge link.aclk)
  begin
    coef_ff <= nxt_coef;
  end

  // ----------------------------------------
  // products, [output channel][input channel]
  // ----------------------------------------
  cmm_pkg::prod_t prod_ff [`CMM_CHANS][`CMM_CHANS];
  cmm_pkg::prod_t nxt_prod [`CMM_CHANS][`CMM_CHANS];

  always_comb
  begin
    for (int s = 0; s < `CMM_CHANS; s++)
    begin
      for (int p = 0; p < `CMM_CHANS; p++)
      begin
        nxt_prod[s][p] = mul_word(in_ff[p], coef_ff[s][p]);
      end
    end
  end

  always_ff @(posedge link.aclk)
  begin
    prod_ff <= nxt_prod;
  end

  // ----------------------------------------
  // summing tree, split to keep adders short
  // ----------------------------------------
  cmm_pkg::acc_t pab_ff [`CMM_CHANS];
  cmm_pkg::acc_t nxt_pab [`CMM_CHANS];
  cmm_pkg::acc_t pc_ff [`CMM_CHANS];
  cmm_pkg::acc_t nxt_pc [`CMM_CHANS];
  cmm_pkg::acc_t sum_ff [`CMM_CHANS];
  cmm_pkg::acc_t nxt_sum [`CMM_CHANS];
  cmm_pkg::acc_t dly_ff [`CMM_CHANS];
  cmm_pkg::acc_t nxt_dly [`CMM_CHANS];

  always_comb
  begin
    for (int s = 0; s < `CMM_CHANS; s++)
    begin
      nxt_pab[s] = widen(prod_ff[s][0]) + widen(prod_ff[s][1]);
      nxt_pc[s] = widen(prod_ff[s][2]);
      nxt_sum[s] = pab_ff[s] + pc_ff[s];
      // spare stage keeps the unrounded sum, so latency lands on five
      nxt_dly[s] = sum_ff[s];
    end
  end

  always_ff @(posedge link.aclk)
  begin
    pab_ff <= nxt_pab;
    pc_ff <= nxt_pc;
    sum_ff <= nxt_sum;
    dly_ff <= nxt_dly;
  end

  // ----------------------------------------
  // rounding output stage
  // ----------------------------------------
  cmm_pkg::data_t out_ff [`CMM_CHANS];
  cmm_pkg::data_t nxt_out [`CMM_CHANS];

  // overflow wraps; the driver must bound the inputs
  always_comb
  begin
    for (int s = 0; s < `CMM_CHANS; s++)
    begin
      nxt_out[s] = round_word(dly_ff[s]);
    end
  end

  always_ff @(posedge link.aclk)
  begin
    out_ff <= nxt_out;
  end

  assign link.out_chan_first = out_ff[0];
  assign link.out_chan_second = out_ff[1];
  assign link.out_chan_third = out_ff[2];

endmodule // cmm_device

// ---- rtl/cmm_host.sv ----
// host end: AXI4-Lite controlled pixel source and sink for the multiplier
`timescale 1ns/100ps
`include "cmm_defs.svh"
module cmm_host
#(
  parameter int IN_W = `CMM_DATA_W,
  parameter int SCALE_W = 2
)
(
  cmm_if.host link,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic pix_in_valid,
  input wire logic [IN_W-1:0] pix_in_first,
  input wire logic [IN_W-1:0] pix_in_second,
  input wire logic [IN_W-1:0] pix_in_third,
  output logic pix_out_valid,
  output logic [`CMM_DATA_W-1:0] pix_out_first,
  output logic [`CMM_DATA_W-1:0] pix_out_second,
  output logic [`CMM_DATA_W-1:0] pix_out_third
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // sign-extend, upscale, then clamp so the upscaled word fits the 12-bit link word
  function automatic cmm_pkg::data_t to_link
  (
    input logic [IN_W-1:0] v,
    input logic [SCALE_W-1:0] sh
  );
    logic signed [`CMM_WIDE_W-1:0] w;
    w = `CMM_WIDE_W'(signed'(v));
    w = w <<< sh;
    if (w > `CMM_DATA_MAX)
      to_link = cmm_pkg::data_t'(`CMM_DATA_MAX);
    else if (w < `CMM_DATA_MIN)
      to_link = cmm_pkg::data_t'(`CMM_DATA_MIN);
    else
      to_link = w[`CMM_DATA_W-1:0];
  endfunction

  function automatic logic [31:0] merge
  (
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] strb
  );
    merge = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        merge[8*b +: 8] = nw[8*b +: 8];
    end
  endfunction

  // ----------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------
  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [3:0] waddr_ff, nxt_waddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata, coef_ff, nxt_coef;
  logic [SCALE_W-1:0] scale_ff, nxt_scale;
  logic [1:0] last_sel_ff, nxt_last_sel;
  logic [7:0] loads_ff, nxt_loads;
  logic [`CMM_LATENCY:0] vld_pipe_ff;
  cmm_pkg::sel_t sel_drv_ff, nxt_sel_drv;
  cmm_pkg::coef_t kdrv_ff [`CMM_CHANS];
  cmm_pkg::coef_t nxt_kdrv [`CMM_CHANS];

  always_comb
  begin
    nxt_aw_have = aw_have_ff | (awvalid & awready_ff);
    nxt_w_have = w_have_ff | (wvalid & wready_ff);
    nxt_waddr = (awvalid & awready_ff) ? awaddr[3:0] : waddr_ff;
    nxt_wdata = (wvalid & wready_ff) ? wdata : wdata_ff;
    nxt_wstrb = (wvalid & wready_ff) ? wstrb : wstrb_ff;
    nxt_bvalid = bvalid_ff & ~bready;
    nxt_bresp = bresp_ff;
    nxt_coef = coef_ff;
    nxt_scale = scale_ff;
    nxt_last_sel = last_sel_ff;
    nxt_loads = loads_ff;
    nxt_sel_drv = cmm_pkg::SEL_HOLD;
    nxt_kdrv = kdrv_ff;
    if (aw_have_ff && w_have_ff && !bvalid_ff)
    begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `CMM_RESP_OKAY;
      case (waddr_ff)
        `CMM_REG_COEF: nxt_coef = merge(coef_ff, wdata_ff, wstrb_ff);
        `CMM_REG_SCALE:
        begin
          if (wstrb_ff[0])
            nxt_scale = wdata_ff[SCALE_W-1:0];
        end
        `CMM_REG_CMD:
        begin
          if (wstrb_ff[0])
          begin
            // one-cycle write pulse; the select drops back to hold after
            nxt_sel_drv = cmm_pkg::sel_t'(wdata_ff[1:0]);
            nxt_last_sel = wdata_ff[1:0];
            nxt_loads = loads_ff + 8'h01;
            for (int p = 0; p < `CMM_CHANS; p++)
            begin
              nxt_kdrv[p] = coef_ff[`CMM_COEF_W*p +: `CMM_COEF_W];
            end
          end
        end
        default: nxt_bresp = `CMM_RESP_SLVERR;
      endcase
    end
    nxt_awready = ~nxt_aw_have & ~nxt_bvalid;
    nxt_wready = ~nxt_w_have & ~nxt_bvalid;
    nxt_rvalid = rvalid_ff & ~rready;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (arvalid && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `CMM_RESP_OKAY;
      case (araddr[3:0])
        `CMM_REG_COEF: nxt_rdata = coef_ff;
        `CMM_REG_SCALE: nxt_rdata = 32'(scale_ff);
        `CMM_REG_CMD: nxt_rdata = {30'h0, last_sel_ff};
        `CMM_REG_STATUS: nxt_rdata = {16'h0, loads_ff, 5'h0, |vld_pipe_ff, last_sel_ff};
        default:
        begin
          nxt_rdata = 32'h0;
          nxt_rresp = `CMM_RESP_SLVERR;
        end
      endcase
    end
    nxt_arready = ~nxt_rvalid;
  end

  always_ff @(posedge link.aclk)
  begin
    if (!link.aresetn)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      waddr_ff <= 4'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `CMM_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `CMM_RESP_OKAY;
      coef_ff <= `CMM_COEF_RST;
      scale_ff <= `CMM_SCALE_RST;
      last_sel_ff <= `CMM_SEL_HOLD;
      loads_ff <= 8'h0;
      sel_drv_ff <= cmm_pkg::SEL_HOLD;
      kdrv_ff <= '{default: '0};
    end
    else
    begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      coef_ff <= nxt_coef;
      scale_ff <= nxt_scale;
      last_sel_ff <= nxt_last_sel;
      loads_ff <= nxt_loads;
      sel_drv_ff <= nxt_sel_drv;
      kdrv_ff <= nxt_kdrv;
    end
  end

  // ----------------------------------------
  // pixel path
  // ----------------------------------------
  cmm_pkg::data_t drv_ff [`CMM_CHANS];
  cmm_pkg::data_t nxt_drv [`CMM_CHANS];
  cmm_pkg::data_t pout_ff [`CMM_CHANS];
  cmm_pkg::data_t nxt_pout [`CMM_CHANS];
  logic drv_vld_ff, pout_vld_ff;
  logic [`CMM_LATENCY:0] nxt_vld_pipe;

  // drive words update every cycle; valid tracks the fixed device latency
  always_comb
  begin
    nxt_drv[0] = to_link(pix_in_first, scale_ff);
    nxt_drv[1] = to_link(pix_in_second, scale_ff);
    nxt_drv[2] = to_link(pix_in_third, scale_ff);
    nxt_vld_pipe = {vld_pipe_ff[`CMM_LATENCY-1:0], drv_vld_ff};
    // link words are plain vectors; sign them so the down-shift is arithmetic
    nxt_pout[0] = $signed(link.out_chan_first) >>> scale_ff;
    nxt_pout[1] = $signed(link.out_chan_second) >>> scale_ff;
    nxt_pout[2] = $signed(link.out_chan_third) >>> scale_ff;
  end

  always_ff @(posedge link.aclk)
  begin
    drv_ff <= nxt_drv;
    pout_ff <= nxt_pout;
    if (!link.aresetn)
    begin
      drv_vld_ff <= 1'b0;
      vld_pipe_ff <= '0;
      pout_vld_ff <= 1'b0;
    end
    else
    begin
      drv_vld_ff <= pix_in_valid;
      vld_pipe_ff <= nxt_vld_pipe;
      pout_vld_ff <= vld_pipe_ff[`CMM_LATENCY];
    end
  end

  assign link.in_chan_first = drv_ff[0];
  assign link.in_chan_second = drv_ff[1];
  assign link.in_chan_third = drv_ff[2];
  assign link.coef_port_first = kdrv_ff[0];
  assign link.coef_port_second = kdrv_ff[1];
  assign link.coef_port_third = kdrv_ff[2];
  assign link.coef_write_select = sel_drv_ff;
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign pix_out_valid = pout_vld_ff;
  assign pix_out_first = pout_ff[0];
  assign pix_out_second = pout_ff[1];
  assign pix_out_third = pout_ff[2];

endmodule // cmm_host

// ---- bench/cmm_checker.sv ----
// concurrent checks on the pixel and coefficient link
`timescale 1ns/100ps
module cmm_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] in_chan_first,
  input wire logic [11:0] in_chan_second,
  input wire logic [11:0] in_chan_third,
  input wire logic [9:0] coef_port_first,
  input wire logic [9:0] coef_port_second,
  input wire logic [9:0] coef_port_third,
  input wire logic [1:0] coef_write_select,
  input wire logic [11:0] out_chan_first,
  input wire logic [11:0] out_chan_second,
  input wire logic [11:0] out_chan_third
);
  // ----------------------------------------
  // shadow coefficient sets and fill count
  // ----------------------------------------
  logic [29:0] shd_ff [3];
  logic [29:0] nxt_shd [3];
  logic [2:0] seen_ff;
  logic [2:0] nxt_seen;
  logic [2:0] fill_ff;
  logic [2:0] nxt_fill;
  logic rdy;
  logic [29:0] kin;
  logic [35:0] din;
  logic [11:0] exp_first;
  logic [11:0] exp_second;
  logic [11:0] exp_third;

  function automatic logic [11:0] dot(input logic [35:0] d, input logic [29:0] k);
    logic signed [23:0] a;
    a = 24'sh100;
    for (int i = 0; i < 3; i++)
      a += $signed(d[12*i +: 12]) * $signed(k[10*i +: 10]);
    return a[20:9];
  endfunction

  assign rdy = fill_ff == 3'h7;
  assign kin = {coef_port_third, coef_port_second, coef_port_first};
  assign din = {in_chan_third, in_chan_second, in_chan_first};
  assign exp_first = dot(din, shd_ff[0]);
  assign exp_second = dot(din, shd_ff[1]);
  assign exp_third = dot(din, shd_ff[2]);

  // shadow lands one edge before the device set: that is the edge new data meets it
  always_comb
  begin
    nxt_shd = shd_ff;
    nxt_seen = aresetn ? seen_ff : 3'h0;
    nxt_fill = !aresetn ? 3'h0 : fill_ff + {2'h0, &seen_ff && !rdy};
    if (aresetn && coef_write_select != 2'h0)
    begin
      nxt_shd[coef_write_select - 2'h1] = kin;
      nxt_seen[coef_write_select - 2'h1] = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    shd_ff <= nxt_shd;
    seen_ff <= nxt_seen;
    fill_ff <= nxt_fill;
  end

  default clocking dck @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  first_match_a: assert property (rdy |-> out_chan_first == $past(exp_first, 6))
    else $error("first output is not the rounded sum");
  second_match_a: assert property (rdy |-> out_chan_second == $past(exp_second, 6))
    else $error("second output is not the rounded sum");
  third_match_a: assert property (rdy |-> out_chan_third == $past(exp_third, 6))
    else $error("third output is not the rounded sum");
  sel_pulse_a: assert property (coef_write_select != 2'h0 |=> coef_write_select == 2'h0)
    else $error("write select stands over one cycle");
  sel_gap_a: assert property (coef_write_select != 2'h0 |=> (coef_write_select == 2'h0) [*2])
    else $error("write selects too close together");
  // a hold command may move the ports, so only the cycle after a pulse is pinned
  coef_stable_a: assert property (coef_write_select != 2'h0 |=> $stable(kin))
    else $error("coefficient ports moved right after a write");
  zero_in_a: assert property (rdy && din == 36'h0 |-> ##6 {out_chan_third, out_chan_second,
    out_chan_first} == 36'h0)
    else $error("zero input gave nonzero output");
  stream_a: assert property (rdy && $past(exp_first, 6) != $past(exp_first, 7)
    |-> out_chan_first != $past(out_chan_first))
    else $error("output missed a new result");

  cover property (coef_write_select == 2'h3);
  cover property (rdy && din == 36'h800800800);
  cover property (rdy && din == 36'h0);
endmodule // cmm_checker

// ---- bench/colorspace_matrix_multiplier_tb.sv ----
// self-checking bench for both matrix multiplier ends
`timescale 1ns/100ps
`include "cmm_defs.svh"
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      miscompares++; \
      $display("unexpected %s: expected %h, seen %h", nm, ex, got); \
    end \
  end
module colorspace_matrix_multiplier_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic pix_in_valid = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [11:0] pix_in_first = 12'h0;
  logic [11:0] pix_in_second = 12'h0;
  logic [11:0] pix_in_third = 12'h0;
  logic awready, wready, bvalid, arready, rvalid, pix_out_valid;
  logic [1:0] bresp, rresp, scl = 2'h0;
  logic [31:0] rdata, cw, seed = 32'h728c;
  logic [11:0] pix_out_first, pix_out_second, pix_out_third;
  logic [29:0] kb [3];
  logic [7:0] ncmd = 8'h0;
  logic [35:0] eq;
  logic [35:0] expq [$];
  int miscompares = 0;
  int compares = 0;
  int nskip = 0;

  always #2.5 aclk = ~aclk;

  cmm_if cmm_if_inst (.aclk(aclk), .aresetn(aresetn));
  cmm_device cmm_device_inst (.link(cmm_if_inst));
  cmm_host cmm_host_inst
  (
    .link(cmm_if_inst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pix_in_valid(pix_in_valid), .pix_in_first(pix_in_first),
    .pix_in_second(pix_in_second), .pix_in_third(pix_in_third),
    .pix_out_valid(pix_out_valid), .pix_out_first(pix_out_first),
    .pix_out_second(pix_out_second), .pix_out_third(pix_out_third)
  );
  cmm_checker cmm_checker_inst
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_chan_first(cmm_if_inst.in_chan_first),
    .in_chan_second(cmm_if_inst.in_chan_second),
    .in_chan_third(cmm_if_inst.in_chan_third),
    .coef_port_first(cmm_if_inst.coef_port_first),
    .coef_port_second(cmm_if_inst.coef_port_second),
    .coef_port_third(cmm_if_inst.coef_port_third),
    .coef_write_select(cmm_if_inst.coef_write_select),
    .out_chan_first(cmm_if_inst.out_chan_first),
    .out_chan_second(cmm_if_inst.out_chan_second),
    .out_chan_third(cmm_if_inst.out_chan_third)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // host path: scale up and clamp, product sum, round, scale back down
  function automatic logic [35:0] model(input logic [35:0] d);
    logic [35:0] r;
    logic signed [23:0] a;
    logic signed [15:0] v;
    for (int o = 0; o < 3; o++)
    begin
      a = 24'sh100;
      for (int i = 0; i < 3; i++)
      begin
        v = $signed(d[12*i +: 12]) <<< scl;
        v = v > `CMM_DATA_MAX ? `CMM_DATA_MAX : (v < `CMM_DATA_MIN ? `CMM_DATA_MIN : v);
        a += $signed(v[11:0]) * $signed(kb[o][10*i +: 10]);
      end
      r[12*o +: 12] = $signed(a[20:9]) >>> scl;
    end
    return r;
  endfunction

  task automatic wrap_up();
    $display("counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200)
    begin
      miscompares++;
      wrap_up();
    end
  endtask

  task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= {28'h0, ad};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      step(n);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [3:0] ad, input logic [31:0] ex, input logic [31:0] msk,
    input logic [1:0] er);
    int n;
    n = 0;
    araddr <= {28'h0, ad};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      step(n);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rdata", ex & msk, rdata & msk)
    `CHK("rresp", er, rresp)
    @(posedge aclk);
  endtask

  task automatic load(input logic [1:0] s, input logic [31:0] c);
    axi_wr(`CMM_REG_COEF, c, `CMM_RESP_OKAY);
    axi_rd(`CMM_REG_COEF, c, 32'hffffffff, `CMM_RESP_OKAY);
    axi_wr(`CMM_REG_CMD, {30'h0, s}, `CMM_RESP_OKAY);
    if (s != 2'h0)
      kb[s - 2'h1] = c[29:0];
    ncmd++;
    axi_rd(`CMM_REG_STATUS, {16'h0, ncmd, 6'h0, s}, 32'h0000ff07, `CMM_RESP_OKAY);
  endtask

  // corner words first: both extremes overflow and must wrap, then zero
  task automatic stream(input int cnt, input bit chk);
    logic [63:0] t;
    int n;
    for (int i = 0; i < cnt; i++)
    begin
      t = {rnd(), rnd()};
      t = i == 0 ? 64'h800800800 : (i == 1 ? 64'h7ff7ff7ff : (i == 2 ? 64'h0 : t));
      pix_in_valid <= 1'b1;
      {pix_in_third, pix_in_second, pix_in_first} <= t[35:0];
      if (chk)
        expq.push_back(model(t[35:0]));
      else
        nskip++;
      @(posedge aclk);
    end
    pix_in_valid <= 1'b0;
    n = 0;
    while (expq.size() > 0 || nskip > 0)
      step(n);
  endtask

  // unloaded coefficient sets give undefined results, so those are only counted
  always @(posedge aclk)
    if (pix_out_valid === 1'b1)
    begin
      if (nskip > 0)
        nskip--;
      else
      begin
        eq = expq.size() > 0 ? expq.pop_front() : 36'hx;
        `CHK("pixel", eq, {pix_out_third, pix_out_second, pix_out_first})
      end
    end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(`CMM_REG_COEF, `CMM_COEF_RST, 32'hffffffff, `CMM_RESP_OKAY);
    axi_rd(`CMM_REG_SCALE, 32'h0, 32'hffffffff, `CMM_RESP_OKAY);
    axi_rd(`CMM_REG_STATUS, 32'h0, 32'h0000ff07, `CMM_RESP_OKAY);
    axi_rd(4'h2, 32'h0, 32'hffffffff, `CMM_RESP_SLVERR);
    axi_wr(4'h6, 32'h3, `CMM_RESP_SLVERR);
    stream(4, 1'b0);
    $display("test registers and refusals done");
    for (int s = 1; s < 4; s++)
      load(s[1:0], s == 1 ? 32'h2007fe00 : rnd());
    stream(40, 1'b1);
    $display("test three sets done");
    load(2'h0, rnd());
    stream(20, 1'b1);
    $display("test hold select done");
    cw = rnd();
    axi_wr(`CMM_REG_COEF, cw, `CMM_RESP_OKAY);
    wstrb <= 4'h2;
    axi_wr(`CMM_REG_COEF, ~cw, `CMM_RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(`CMM_REG_COEF, {cw[31:16], ~cw[15:8], cw[7:0]}, 32'hffffffff, `CMM_RESP_OKAY);
    $display("test byte strobes done");
    for (int k = 1; k < 4; k++)
    begin
      axi_wr(`CMM_REG_SCALE, {30'h0, k[1:0]}, `CMM_RESP_OKAY);
      scl = k[1:0];
      stream(16, 1'b1);
    end
    $display("test scaling done");
    wrap_up();
  end
endmodule // colorspace_matrix_multiplier_tb
